// file: logic/scm_clock_mode_selector.sv
// System clock mode word, PLL dividers and glitch-free source selector
//
// Notes on behaviour
// - The PLL is powered by mode bit 24 and needs the crystal input enabled.
// - The crystal clock is divided by the reference field plus one for the comparator.
// - The VCO is divided by the feedback field plus one for the comparator.
// - Post field 15 passes the VCO, any other value divides it by 2*(field+1).
// - Crystal field 00 floats the pads, other values enable them with none, 15 pF or 30 pF loading.
// - Source select 11 PLL, 10 crystal, 01 slow oscillator, 00 fast oscillator used at boot.
// - A switch waits for an old rising edge, holds high, then waits for a new rising edge.
// - The mode word holds source, crystal, post, feedback, reference and enable from bit 0 up.
//
// The implementer's own choices: the register addresses and the APB register port.
`include "scm_params.svh"
`default_nettype none
module scm_clock_mode_selector (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [7:0]       paddr_i,
    input  wire logic [31:0]      pwdata_i,
    input  wire logic [3:0]       pstrb_i,
    output logic      [31:0]      prdata_o,
    output logic                  pready_o,
    output logic                  pslverr_o,
    input  wire logic             internal_fast_osc_i,
    input  wire logic             internal_slow_osc_i,
    input  wire logic             crystal_in_i,
    input  wire logic             vco_i,
    output logic                  sys_clk_o,
    output scm_pkg::scm_src_t     cur_src_o,
    output logic                  pll_en_o,
    output logic                  ref_clk_o,
    output logic                  fb_clk_o,
    output logic                  pll_clk_o,
    output logic                  crystal_in_en_o,
    output logic                  crystal_out_o,
    output logic                  crystal_out_oe_o,
    output logic      [1:0]       load_cap_sel_o
);
    import scm_pkg::*;

    scm_state_t st;
    scm_state_t nx;
    logic [3:0] lvl;
    logic [3:0] prv;
    logic [3:0] rise;
    logic       xt_on;
    logic       vco_rise;
    logic       acc;
    logic       wr_mode;
    logic [31:0] wtmp;

    // *****************************************************************
    // Next-state logic
    // *****************************************************************

    // One process builds the whole next state
    always_comb begin
        nx = st;
        wtmp = 32'h0000_0000;
        // Two-flop synchronisers; s3 only serves edge detection
        nx.s1 = {vco_i, crystal_in_i, internal_slow_osc_i, internal_fast_osc_i};
        nx.s2 = st.s1;
        nx.s3 = st.s2;
        xt_on = st.mode[`SCM_XCFG_F] != `SCM_XCFG_OFF;
        // Crystal level is ignored while its pads are off
        lvl = {st.pll_clk, st.s2[`SCM_I_XTAL] & xt_on, st.s2[`SCM_I_SLOW], st.s2[`SCM_I_FAST]};
        prv = {st.pll_prev, st.s3[`SCM_I_XTAL] & xt_on, st.s3[`SCM_I_SLOW], st.s3[`SCM_I_FAST]};
        rise = lvl & ~prv;
        vco_rise = st.s2[`SCM_I_VCO] & ~st.s3[`SCM_I_VCO];

        // Pad controls follow the crystal field
        nx.pad_en = xt_on;
        nx.caps = xt_on ? 2'(st.mode[`SCM_XCFG_F] - 2'h1) : 2'h0;
        nx.xo = xt_on & ~st.s2[`SCM_I_XTAL];

        // PLL dividers, held cleared while the PLL is powered down
        if (!st.mode[`SCM_PLLEN_B]) begin
            nx.ref_cnt = 6'h00;
            nx.fb_cnt = 10'h000;
            nx.post_cnt = 4'h0;
            nx.ref_clk = 1'b0;
            nx.fb_clk = 1'b0;
            nx.pll_clk = 1'b0;
        end else begin
            // Wrap with >= so a smaller new ratio never overruns
            // A ratio written below the current count restarts the count at once
            if (st.ref_cnt > st.mode[`SCM_REF_F]) begin
                nx.ref_cnt = 6'h00;
            end else if (rise[`SCM_I_XTAL]) begin
                nx.ref_cnt = (st.ref_cnt >= st.mode[`SCM_REF_F]) ? 6'h00 : 6'(st.ref_cnt + 6'h01);
            end
            nx.ref_clk = lvl[`SCM_I_XTAL] & (nx.ref_cnt == 6'h00);
            if (st.fb_cnt > st.mode[`SCM_FB_F]) begin
                nx.fb_cnt = 10'h000;
            end else if (vco_rise) begin
                nx.fb_cnt = (st.fb_cnt >= st.mode[`SCM_FB_F]) ? 10'h000 : 10'(st.fb_cnt + 10'h001);
            end
            nx.fb_clk = st.s2[`SCM_I_VCO] & (nx.fb_cnt == 10'h000);
            if (st.mode[`SCM_POST_F] == `SCM_POST_BYPASS) begin
                nx.post_cnt = 4'h0;
                nx.pll_clk = st.s2[`SCM_I_VCO];
            end else if (st.post_cnt > st.mode[`SCM_POST_F]) begin
                nx.post_cnt = 4'h0;
            end else if (vco_rise) begin
                // Toggle every field+1 edges, a ratio of 2*(field+1)
                if (st.post_cnt >= st.mode[`SCM_POST_F]) begin
                    nx.post_cnt = 4'h0;
                    nx.pll_clk = ~st.pll_clk;
                end else begin
                    nx.post_cnt = 4'(st.post_cnt + 4'h1);
                end
            end
        end
        nx.pll_prev = st.pll_clk;

        // Source hand-over; scm_sel_new follows the source field as it stands, so a source changed mid-switch is taken in the same hand-over
        case (st.sel)
            scm_sel_run: begin
                nx.sys_clk = lvl[st.cur_src];
                if (st.mode[`SCM_SRC_F] != st.cur_src) begin
                    nx.sel = scm_sel_old;
                end
            end
            scm_sel_old: begin
                nx.sys_clk = lvl[st.cur_src];
                if (rise[st.cur_src]) begin
                    nx.sys_clk = 1'b1;
                    nx.sel = scm_sel_new;
                end
            end
            scm_sel_new: begin
                nx.sys_clk = 1'b1;
                if (rise[st.mode[`SCM_SRC_F]]) begin
                    nx.cur_src = scm_src_t'(st.mode[`SCM_SRC_F]);
                    nx.sel = scm_sel_run;
                end
            end
            default: begin
                nx.sel = scm_sel_run;
            end
        endcase

        // APB slave with one wait state
        acc = psel_i & penable_i;
        nx.pready = acc & ~st.pready;
        nx.pslverr = 1'b0;
        nx.prdata = 32'h0000_0000;
        if (acc & ~st.pready) begin
            if (paddr_i == `SCM_OFS_MODE) begin
                nx.prdata = {7'h00, st.mode};
            end else if (paddr_i == `SCM_OFS_STATUS) begin
                nx.prdata = {28'h000_0000, st.sel, st.cur_src};
            end else begin
                nx.pslverr = 1'b1;
            end
        end
        // Byte lanes allow a low-bits-only source change
        wr_mode = acc & st.pready & pwrite_i & (paddr_i == `SCM_OFS_MODE);
        if (wr_mode) begin
            wtmp = {7'h00, st.mode};
            for (int b = 0; b < 4; b++) begin
                if (pstrb_i[b]) begin
                    wtmp[b*8 +: 8] = pwdata_i[b*8 +: 8];
                end
            end
            nx.mode = wtmp[24:0];
        end
    end

    // *****************************************************************
    // State register
    // *****************************************************************

    // Reset: fast source, PLL off, pads floating
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
            st.mode <= `SCM_MODE_RST;
            st.cur_src <= scm_src_fast;
            st.sel <= scm_sel_run;
        end else begin
            st <= nx;
        end
    end

    // Outputs straight from the state register
    assign prdata_o = st.prdata;
    assign pready_o = st.pready;
    assign pslverr_o = st.pslverr;
    assign sys_clk_o = st.sys_clk;
    assign cur_src_o = st.cur_src;
    assign pll_en_o = st.mode[`SCM_PLLEN_B];
    assign ref_clk_o = st.ref_clk;
    assign fb_clk_o = st.fb_clk;
    assign pll_clk_o = st.pll_clk;
    assign crystal_in_en_o = st.pad_en;
    assign crystal_out_o = st.xo;
    assign crystal_out_oe_o = st.pad_en;
    assign load_cap_sel_o = st.caps;

    // *****************************************************************
    // Assertions
    // *****************************************************************

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // Enable bit of a write reaches the PLL power control
    AST_PLL_EN: assert property (wr_mode & pstrb_i[3] |=> pll_en_o == $past(pwdata_i[24]))
        else $error("pll enable does not follow written bit");
    // Reference counter stays inside its ratio
    AST_REF_RANGE: assert property (pll_en_o & $stable(st.mode) |-> st.ref_cnt <= st.mode[`SCM_REF_F])
        else $error("reference divider overran");
    // Feedback counter stays inside its ratio
    AST_FB_RANGE: assert property (pll_en_o & $stable(st.mode) |-> st.fb_cnt <= st.mode[`SCM_FB_F])
        else $error("feedback divider overran");
    // Bypass passes the synchronised VCO level
    AST_POST_BYP: assert property (pll_en_o & st.mode[`SCM_POST_F] == `SCM_POST_BYPASS
            |=> pll_clk_o == $past(st.s2[`SCM_I_VCO]) || !pll_en_o)
        else $error("post divider bypass broken");
    // Floating pads when crystal is off
    AST_XO_FLOAT: assert property (st.mode[`SCM_XCFG_F] == `SCM_XCFG_OFF ##1 $stable(st.mode)
            |-> !crystal_out_oe_o && load_cap_sel_o == 2'h0)
        else $error("crystal pads driven while off");
    // Running on fast source follows that oscillator
    AST_RUN_FAST: assert property (st.sel == scm_sel_run && st.cur_src == scm_src_fast
            |=> sys_clk_o == $past(st.s2[`SCM_I_FAST]))
        else $error("system clock not following fast source");
    // Output held high while awaiting the new edge
    AST_HOLD_HIGH: assert property (st.sel == scm_sel_new |-> ##1 sys_clk_o)
        else $error("output not held high during hand-over");
    // Low-lane-only write keeps the feedback, reference and enable fields
    AST_LOW_WRITE: assert property (wr_mode && pstrb_i == 4'h1 |=> st.mode[24:8] == $past(st.mode[24:8]))
        else $error("partial write disturbed upper fields");

    // Powered-down PLL keeps every derived clock low
    AST_PLL_OFF: assert property (!pll_en_o
            |=> !ref_clk_o && !fb_clk_o && !pll_clk_o)
        else $error("pll clocks active while powered down");
    // Loading caps follow the crystal field minus one
    AST_CAP_MAP: assert property (st.mode[`SCM_XCFG_F] != `SCM_XCFG_OFF
            |=> crystal_out_oe_o && load_cap_sel_o == 2'($past(st.mode[`SCM_XCFG_F]) - 2'h1))
        else $error("loading cap select wrong");
    // Undriven pad carries no level
    AST_XO_QUIET: assert property (!crystal_out_oe_o
            |-> !crystal_out_o)
        else $error("crystal out level while floating");
    // Source in use only changes at the end of a hand-over
    AST_SRC_STEP: assert property (cur_src_o != $past(cur_src_o)
            |-> $past(st.sel) == scm_sel_new)
        else $error("source changed outside hand-over");
    // Leaving the old source drives the output high
    AST_OLD_EDGE: assert property (st.sel == scm_sel_old ##1 st.sel == scm_sel_new
            |-> sys_clk_o)
        else $error("old source released low");
    // Running state passes the selected source level
    AST_RUN_SRC: assert property (st.sel == scm_sel_run
            |=> sys_clk_o == $past(lvl[st.cur_src]))
        else $error("system clock not following source");
    // A new source code starts a hand-over
    AST_SWITCH_START: assert property (st.sel == scm_sel_run && st.mode[`SCM_SRC_F] != st.cur_src
            |=> st.sel == scm_sel_old)
        else $error("source change not started");
    // Full-lane write takes the whole word in one cycle
    AST_FULL_WRITE: assert property (wr_mode && pstrb_i == 4'hf
            |=> st.mode == $past(pwdata_i[24:0]))
        else $error("full write not latched");
    // Ready is a single-cycle pulse
    AST_PREADY_PULSE: assert property (pready_o
            |=> !pready_o)
        else $error("pready held longer than one cycle");
    // Error only comes with ready
    AST_ERR_READY: assert property (pslverr_o
            |-> pready_o)
        else $error("pslverr without pready");
    // Read data is zero outside the answer cycle
    AST_RDATA_IDLE: assert property (!pready_o
            |-> prdata_o == 32'h0000_0000)
        else $error("read data outside answer cycle");
    // Post counter stays inside its ratio
    AST_POST_RANGE: assert property (pll_en_o && st.mode[`SCM_POST_F] != `SCM_POST_BYPASS && $stable(st.mode)
            |-> st.post_cnt <= st.mode[`SCM_POST_F])
        else $error("post divider overran");
    // Bypass keeps the post counter cleared
    AST_BYP_CNT: assert property (pll_en_o && st.mode[`SCM_POST_F] == `SCM_POST_BYPASS
            |=> st.post_cnt == 4'h0)
        else $error("post counter running in bypass");

    // *****************************************************************
    // Cover points
    // *****************************************************************

    // Main hand-over scenarios and a bad address
    COV_TO_PLL: cover property (st.sel == scm_sel_new ##1 st.cur_src == scm_src_pll);
    COV_TO_XTAL: cover property (st.sel == scm_sel_new ##1 st.cur_src == scm_src_xtal);
    COV_HOLD: cover property (st.sel == scm_sel_old ##1 st.sel == scm_sel_new);
    COV_TO_SLOW: cover property (st.sel == scm_sel_old ##[1:200] st.cur_src == scm_src_slow);
    COV_BAD_ADDR: cover property (pslverr_o);
endmodule : scm_clock_mode_selector
`default_nettype wire

// file: logic/scm_params.svh
// Offsets, field positions and reset values of the clock mode selector
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH
`define SCM_OFS_MODE     8'h00
`define SCM_OFS_STATUS   8'h04
`define SCM_MODE_RST     25'h000_0000
`define SCM_SRC_F        1:0
`define SCM_XCFG_F       3:2
`define SCM_POST_F       7:4
`define SCM_FB_F         17:8
`define SCM_REF_F        23:18
`define SCM_PLLEN_B      24
`define SCM_POST_BYPASS  4'hf
`define SCM_XCFG_OFF     2'h0
`define SCM_I_FAST       0
`define SCM_I_SLOW       1
`define SCM_I_XTAL       2
`define SCM_I_VCO        3
`endif

// file: logic/scm_pkg.sv
// Types of the system clock mode selector
`default_nettype none
package scm_pkg;
    // Clock source codes as held in the low two bits of the mode word
    typedef enum logic [1:0] {
        scm_src_fast = 2'b00,
        scm_src_slow = 2'b01,
        scm_src_xtal = 2'b10,
        scm_src_pll  = 2'b11
    } scm_src_t;

    // Glitch-free hand-over states
    typedef enum logic [1:0] {
        scm_sel_run  = 2'b00,
        scm_sel_old  = 2'b01,
        scm_sel_new  = 2'b10
    } scm_sel_t;

    // Whole state of the selector
    typedef struct packed {
        logic [3:0]  s1;
        logic [3:0]  s2;
        logic [3:0]  s3;
        logic [24:0] mode;
        scm_src_t    cur_src;
        scm_sel_t    sel;
        logic        sys_clk;
        logic [5:0]  ref_cnt;
        logic [9:0]  fb_cnt;
        logic [3:0]  post_cnt;
        logic        ref_clk;
        logic        fb_clk;
        logic        pll_clk;
        logic        pll_prev;
        logic        pad_en;
        logic [1:0]  caps;
        logic        xo;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } scm_state_t;
endpackage : scm_pkg
`default_nettype wire

// file: dv/scm_xtal_model.sv
// Crystal on the selector's pad pair, seen from the board side
`default_nettype none
module scm_xtal_model #(
    parameter int HALF_NS = 18
) (
    input  wire logic xo_oe_i,
    output logic      xi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // *******************************************
    // Oscillation needs the pad driver for feedback
    // *******************************************
    initial xi_o = 1'b0;
    // Floating pad wanders fast so an ignored input cannot look quiet
    always begin
        if (xo_oe_i === 1'b1) begin
            #(HALF_NS) xi_o = ~xi_o;
        end else begin
            #3 xi_o = ~xi_o;
        end
    end
endmodule : scm_xtal_model
`default_nettype wire

// file: dv/tb_top.sv
// Testbench of the system clock mode selector
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import scm_pkg::*;
    logic        clock_i, rst_i, psel, penable, pwrite, fast, slow, vco, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd;
    logic [3:0]  pstrb;
    logic [31:0] prdata_o;
    logic        pready_o, pslverr_o, sys_clk_o, pll_en_o, ref_clk_o, fb_clk_o, pll_clk_o;
    logic        xin, xin_en_o, xo_o, xo_oe_o;
    logic [1:0]  cap_o;
    scm_src_t    cur_src_o;
    int          error_cnt, n_checks;
    logic [1:0]  seq [4] = '{2'd2, 2'd1, 2'd3, 2'd0};
    wire logic [3:0] outs = {sys_clk_o, pll_clk_o, fb_clk_o, ref_clk_o};
    wire logic [3:0] srcs = {vco, xin, slow, fast};
    // ****************
    // Clocks and parts
    // ****************
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    // Sources kept far below the sampling rate
    always #10 fast = ~fast;
    always #100 slow = ~slow;
    always #20 vco = ~vco; // VCO kept at one fixed rate
    scm_xtal_model #(.HALF_NS(18)) XTAL (.xo_oe_i(xo_oe_o), .xi_o(xin));
    scm_clock_mode_selector DUT (
        .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .internal_fast_osc_i(fast), .internal_slow_osc_i(slow), .crystal_in_i(xin),
        .vco_i(vco), .sys_clk_o(sys_clk_o), .cur_src_o(cur_src_o), .pll_en_o(pll_en_o), .ref_clk_o(ref_clk_o),
        .fb_clk_o(fb_clk_o), .pll_clk_o(pll_clk_o), .crystal_in_en_o(xin_en_o), .crystal_out_o(xo_o),
        .crystal_out_oe_o(xo_oe_o), .load_cap_sel_o(cap_o));
    // ****************
    // Shared tasks
    // ****************
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One APB transfer; data taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
        int c;
        c = 0;
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge clock_i);
        penable <= 1'b1;
        while (c < 20) begin
            @(posedge clock_i);
            c++;
            if (pready_o === 1'b1) break;
        end
        rd = prdata_o;
        err = pslverr_o;
        if (pready_o !== 1'b1) begin
            error_cnt++;
            $display("BAD pready expected 1 seen %b", pready_o);
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Source rises seen within one period of a derived clock
    task automatic measure(input int oi, input int si, input int exp_n, input string nm);
        int n, c, ph;
        logic o, op, s, sp;
        n = 0;
        c = 0;
        ph = 0;
        op = 1'b1;
        sp = 1'b1;
        while (ph < 2 && c < 3000) begin
            @(posedge clock_i);
            c++;
            o = outs[oi];
            s = srcs[si];
            if (o && !op) ph++;
            if (ph == 1 && s && !sp) n++;
            op = o;
            sp = s;
        end
        if (ph < 2) begin
            error_cnt++;
            $display("BAD %s expected edges seen none", nm);
            report_and_stop();
        end
        chk(nm, exp_n, n);
    endtask : measure
    task automatic wait_src(input logic [1:0] s);
        int c;
        for (c = 0; c < 500 && cur_src_o !== s; c++) @(posedge clock_i);
        chk("cur_src", s, cur_src_o);
        if (cur_src_o !== s) report_and_stop();
    endtask : wait_src
    // ****************
    // Main sequence
    // ****************
    initial begin
        {rst_i, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {fast, slow, vco} = 3'b000;
        rst_i = 1'b1;
        error_cnt = 0;
        n_checks = 0;
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        apb(1'b0, 8'h04, 32'h0, 4'h0);
        chk("status", 32'h0, rd);
        apb(1'b0, 8'h00, 32'h0, 4'h0);
        chk("mode", 32'h0, rd);
        chk("pads", 32'h0, {pll_en_o, xin_en_o, xo_oe_o, cap_o});
        apb(1'b1, 8'h00, 32'hff9d28f8, 4'hf);
        apb(1'b0, 8'h00, 32'h0, 4'h0);
        chk("mode", 32'h019d28f8, rd);
        chk("pll_en", 32'h1, pll_en_o);
        // Low lane only: PLL fields must survive
        for (int cc = 0; cc < 4; cc++) begin
            apb(1'b1, 8'h00, {24'haaaaaa, 4'hf, cc[1:0], 2'b00}, 4'h1);
            repeat (2) @(posedge clock_i);
            chk("pads", {cc != 0, cc != 0, (cc == 0) ? 2'b00 : 2'(cc - 1)}, {xin_en_o, xo_oe_o, cap_o});
        end
        apb(1'b0, 8'h00, 32'h0, 4'h0);
        chk("mode", 32'h019d28fc, rd);
        apb(1'b1, 8'h08, 32'h0, 4'hf);
        chk("wr_err", 32'h1, err);
        apb(1'b0, 8'h08, 32'h0, 4'h0);
        chk("rd_err", 32'h1, {31'h0, err});
        chk("rd_data", 32'h0, rd);
        apb(1'b1, 8'h04, 32'h3, 4'hf);
        chk("ro_err", 32'h0, err);
        apb(1'b0, 8'h00, 32'h0, 4'h0);
        chk("mode", 32'h019d28fc, rd);
        // Settings on while still on the fast oscillator
        apb(1'b1, 8'h00, 32'h01080414, 4'hf);
        measure(0, 2, 3, "ref_div");
        measure(1, 3, 5, "fb_div");
        measure(2, 3, 4, "post_div");
        apb(1'b1, 8'h00, 32'h010804f4, 4'hf);
        measure(2, 3, 1, "post_bypass");
        // Walk every source, leaving the PLL through fast
        foreach (seq[i]) begin
            apb(1'b1, 8'h00, 32'h010804f4 | seq[i], 4'hf);
            wait_src(seq[i]);
            apb(1'b0, 8'h04, 32'h0, 4'h0);
            chk("status", seq[i], rd);
            measure(3, seq[i], 1, "sys_clk");
        end
        apb(1'b1, 8'h00, 32'h0, 4'hf);
        repeat (4) @(posedge clock_i);
        chk("pll_off", 32'h0, {pll_en_o, ref_clk_o, fb_clk_o, pll_clk_o});
        // Reset while running from the crystal
        apb(1'b1, 8'h00, 32'h00000006, 4'hf);
        wait_src(2'd2);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        chk("rst", 32'h0, {cur_src_o, pll_en_o, xin_en_o, xo_oe_o});
        rst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        apb(1'b0, 8'h00, 32'h0, 4'h0);
        chk("mode_rst", 32'h0, rd);
        apb(1'b0, 8'h04, 32'h0, 4'h0);
        chk("status_rst", 32'h0, rd);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
